// ---- rtl/exec_ops_map.vh ----
// Constants for the return, rotate, subtract, swap and xor execution unit
// Assumes inclusion by bare name from the execution unit source
`ifndef EXEC_OPS_MAP_VH
`define EXEC_OPS_MAP_VH

// ==========================================================
// Operation codes
`define OP_NONE 3'h0
`define OP_RETURN 3'h1
`define OP_ROTATE_RIGHT_CARRY 3'h2
`define OP_LITERAL_MINUS_ACC 3'h3
`define OP_REG_MINUS_ACC 3'h4
`define OP_NIBBLE_EXCHANGE 3'h5
`define OP_REG_EXCLUSIVE_OR 3'h6
`define OP_LITERAL_EXCLUSIVE_OR 3'h7

// ==========================================================
// Destination bit values
`define DEST_ACC 1'b0
`define DEST_REG 1'b1

// ==========================================================
// Reset values and timing
`define ACC_RESET 8'h00
`define PC_RESET 13'h0000
`define RETURN_CYCLES 2'h2

`endif

// ---- rtl/exec_ops.v ----
// Execution unit for return, rotate right, subtract, swap and xor operations
// Assumes one operation request per idle cycle, file reads combinational
//
// Function
// [RULE_01] Return pops stack, loads PC, two cycles
// [RULE_02] Rotate right through carry, only carry changes
// [RULE_03] Seven-bit address; dest bit clear selects accumulator
// [RULE_04] Literal minus accumulator into accumulator, C DC Z
// [RULE_05] Register minus accumulator to destination, C DC Z
// [RULE_06] Swap nibbles to destination, flags untouched
// [RULE_07] Register xor accumulator to destination, Z only
// [RULE_08] Literal xor accumulator into accumulator, Z only
// [RULE_09] Carry means no borrow; zero on zero
`include "exec_ops_map.vh"

module exec_ops #(
	parameter PC_WIDTH = 13
)(
	input wire core_clk,
	input wire rst,
	input wire op_valid,
	input wire [2:0] op_code,
	input wire [6:0] file_addr,
	input wire dest_bit,
	input wire [7:0] literal,
	input wire [7:0] file_rdata,
	input wire [PC_WIDTH-1:0] stack_top_entry,
	input wire carry_in,
	input wire digit_carry_in,
	input wire zero_in,
	output reg op_ready,
	output reg [6:0] file_raddr,
	output reg file_we,
	output reg [6:0] file_waddr,
	output reg [7:0] file_wdata,
	output reg [7:0] acc_r,
	output reg carry_flag,
	output reg digit_carry_flag,
	output reg zero_flag,
	output reg flags_we,
	output reg stack_pop,
	output reg pc_load,
	output reg [PC_WIDTH-1:0] pc_value,
	output reg op_done
);

	// ==========================================================
	// Datapath
	reg [7:0] result;
	reg [8:0] diff;
	reg [4:0] low_diff;
	reg [7:0] minuend;
	reg wr_c;
	reg wr_dc;
	reg wr_z;
	reg to_reg;
	reg to_acc;
	reg [1:0] ret_cnt_r;
	reg [1:0] ret_cnt_nxt;
	wire take;

	// Request accepted only while ready is high
	// Ready falls for exactly one cycle after a return is taken,
	// so the caller must hold its request through that cycle.
	assign take = op_valid && op_ready;

	// Operand address straight to the file read port
	always @*
	begin
		file_raddr = file_addr; // see [RULE_03]
	end

	// Result and flag-update selection per operation
	// Borrow is taken from the ninth and fifth difference bits;
	// carry and digit carry are stored inverted (set means no borrow).
	// Rotate takes its old carry from the registered carry flag,
	// which mirrors the outside status copy after every taken op that does not write carry.
	always @*
	begin
		minuend = (op_code == `OP_LITERAL_MINUS_ACC) ? literal : file_rdata;
		diff = {1'b0, minuend} - {1'b0, acc_r};
		low_diff = {1'b0, minuend[3:0]} - {1'b0, acc_r[3:0]};
		result = 8'h00;
		wr_c = 1'b0;
		wr_dc = 1'b0;
		wr_z = 1'b0;
		to_reg = 1'b0;
		to_acc = 1'b0;
		case (op_code)
			`OP_ROTATE_RIGHT_CARRY:
			begin
				result = {carry_flag, file_rdata[7:1]}; // see [RULE_02]
				wr_c = 1'b1;
				to_reg = (dest_bit == `DEST_REG); // see [RULE_03]
				to_acc = (dest_bit == `DEST_ACC);
			end
			`OP_LITERAL_MINUS_ACC:
			begin
				result = diff[7:0]; // see [RULE_04]
				wr_c = 1'b1;
				wr_dc = 1'b1;
				wr_z = 1'b1;
				to_acc = 1'b1;
			end
			`OP_REG_MINUS_ACC:
			begin
				result = diff[7:0]; // see [RULE_05]
				wr_c = 1'b1;
				wr_dc = 1'b1;
				wr_z = 1'b1;
				to_reg = (dest_bit == `DEST_REG);
				to_acc = (dest_bit == `DEST_ACC);
			end
			`OP_NIBBLE_EXCHANGE:
			begin
				result = {file_rdata[3:0], file_rdata[7:4]}; // see [RULE_06]
				to_reg = (dest_bit == `DEST_REG);
				to_acc = (dest_bit == `DEST_ACC);
			end
			`OP_REG_EXCLUSIVE_OR:
			begin
				result = acc_r ^ file_rdata; // see [RULE_07]
				wr_z = 1'b1;
				to_reg = (dest_bit == `DEST_REG);
				to_acc = (dest_bit == `DEST_ACC);
			end
			`OP_LITERAL_EXCLUSIVE_OR:
			begin
				result = acc_r ^ literal; // see [RULE_08]
				wr_z = 1'b1;
				to_acc = 1'b1;
			end
			default:
			begin
				result = 8'h00;
			end
		endcase
	end

	// Return sequencer count
	// Counts down the second cycle of a return; zero means idle
	always @*
	begin
		ret_cnt_nxt = ret_cnt_r;
		if (ret_cnt_r != 2'h0)
			ret_cnt_nxt = ret_cnt_r - 2'h1;
		else if (take && op_code == `OP_RETURN)
			ret_cnt_nxt = `RETURN_CYCLES - 2'h1; // see [RULE_01]
	end

	// ==========================================================
	// Registered state and outputs
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			acc_r <= `ACC_RESET;
			carry_flag <= 1'b0;
			digit_carry_flag <= 1'b0;
			zero_flag <= 1'b0;
			flags_we <= 1'b0;
			file_we <= 1'b0;
			file_waddr <= 7'h00;
			file_wdata <= 8'h00;
			stack_pop <= 1'b0;
			pc_load <= 1'b0;
			pc_value <= {PC_WIDTH{1'b0}};
			op_done <= 1'b0;
			op_ready <= 1'b1;
			ret_cnt_r <= 2'h0;
		end
		else
		begin
			ret_cnt_r <= ret_cnt_nxt;
			file_we <= 1'b0;
			flags_we <= 1'b0;
			stack_pop <= 1'b0;
			pc_load <= 1'b0;
			op_done <= 1'b0;
			// Ready drops for the second cycle of a return
			op_ready <= (ret_cnt_nxt == 2'h0);
			if (ret_cnt_r == 2'h1)
				op_done <= 1'b1; // Return finishes in its second cycle
			if (take)
			begin
				// Flags follow the input copy unless this op updates them
				// Operation code none passes flags through with no pulses
				carry_flag <= carry_in;
				digit_carry_flag <= digit_carry_in;
				zero_flag <= zero_in;
				if (op_code == `OP_RETURN)
				begin
					stack_pop <= 1'b1; // see [RULE_01]
					pc_load <= 1'b1;
					pc_value <= stack_top_entry;
				end
				else if (op_code != `OP_NONE)
				begin
					op_done <= 1'b1;
					flags_we <= wr_c | wr_dc | wr_z;
					if (wr_c && op_code == `OP_ROTATE_RIGHT_CARRY)
						carry_flag <= file_rdata[0]; // see [RULE_02]
					else if (wr_c)
						carry_flag <= ~diff[8]; // see [RULE_09]
					if (wr_dc)
						digit_carry_flag <= ~low_diff[4]; // see [RULE_09]
					if (wr_z)
						zero_flag <= (result == 8'h00); // see [RULE_09]
					if (to_acc)
						acc_r <= result;
					if (to_reg)
					begin
						file_we <= 1'b1;
						file_waddr <= file_addr;
						file_wdata <= result;
					end
				end
			end
		end
	end

endmodule // exec_ops

// ---- test/exec_ops_monitor.sv ----
// Checker for the execution unit
// Assumes binding to exec_ops on one clock
module exec_ops_monitor #(
	parameter PC_WIDTH = 13
)(
	input logic core_clk,
	input logic rst,
	input logic op_valid,
	input logic [2:0] op_code,
	input logic [6:0] file_addr,
	input logic dest_bit,
	input logic [7:0] literal,
	input logic [7:0] file_rdata,
	input logic [PC_WIDTH-1:0] stack_top_entry,
	input logic op_ready,
	input logic file_we,
	input logic [6:0] file_waddr,
	input logic [7:0] acc_r,
	input logic carry_flag,
	input logic flags_we,
	input logic stack_pop,
	input logic pc_load,
	input logic [PC_WIDTH-1:0] pc_value,
	input logic op_done
);
// ==========
// Properties
default clocking mc @(posedge core_clk);
endclocking
default disable iff (rst);
// One-hot of the taken operation
wire [7:0] go = {7'h0, op_valid && op_ready} << op_code;
a_ret_pulse: assert property (go[1] |=> stack_pop && pc_load && !flags_we) else $error("r");
a_ret_target: assert property (go[1] |=> pc_value == $past(stack_top_entry)) else $error("p");
a_ret_two: assert property (go[1] |=> !op_done && !op_ready ##1 op_done) else $error("t");
a_rot_carry: assert property (go[2] && file_rdata[0] |=> carry_flag) else $error("c");
a_lit_sub: assert property (go[3] |=> acc_r == 8'($past(literal) - $past(acc_r))) else $error("s");
a_dest_reg: assert property (|go[6:4] && dest_bit |=> file_we && file_waddr == $past(file_addr)) else $error("d");
a_swap_keep: assert property (go[5] |=> !flags_we) else $error("w");
a_xor_lit: assert property (go[7] |=> acc_r == ($past(literal) ^ $past(acc_r))) else $error("x");
cover property (go[1]);
cover property (go[4] && dest_bit);
cover property (go[3]);
endmodule // exec_ops_monitor
bind exec_ops exec_ops_monitor #(.PC_WIDTH(PC_WIDTH)) i_mon (.*);

// ---- test/tb.sv ----
// Bench for exec_ops with accumulator and flag model
// Assumes random file read data driven here
module tb;
timeunit 1ns;
timeprecision 1ns;
logic core_clk = 0, rst = 1, op_valid = 0, dest_bit = 0, w, carry_in = 0;
logic digit_carry_in = 0, zero_in = 0;
logic [2:0] op_code = 0;
logic [6:0] file_addr = 0;
logic [7:0] literal = 0, file_rdata = 0, acc = 0, r, a;
logic [12:0] stack_top_entry = 0;
logic [31:0] s = 32'hf389_c4c0;
wire op_ready, file_we, carry_flag, digit_carry_flag, zero_flag, flags_we, stack_pop, pc_load;
wire op_done;
wire [6:0] file_waddr, file_raddr;
wire [7:0] file_wdata, acc_r;
wire [12:0] pc_value;
int num_errors = 0, checks_done = 0;
// Clock and unit
always #10 core_clk = ~core_clk;
exec_ops i_exec_ops (.*);
function logic [31:0] xs();
	s ^= s << 13;
	s ^= s >> 17;
	s ^= s << 5;
	return s;
endfunction
task ck(string n, logic [15:0] g, logic [15:0] e);
	checks_done++;
	if (g !== e)
	begin
		num_errors++;
		$display("[ERR] %s exp %h got %h", n, e, g);
	end
endtask
task end_of_test;
	$display("checks %0d errors %0d", checks_done, num_errors);
	if (num_errors == 0 && checks_done > 0)
		$display("NO MISMATCHES");
	else
		$display("MISMATCHES SEEN");
	$finish;
endtask
// Random operations, held request, model compare
initial
begin
	repeat (12) @(negedge core_clk);
	rst = 0;
	op_valid = 1;
	for (int i = 0; i < 400; i++)
	begin
		{literal, file_rdata, file_addr, dest_bit, a} = xs();
		op_code = i < 8 ? 3'(i + 1) : 3'(a % 8);
		stack_top_entry = {a, file_rdata[4:0]};
		if (a[3:0] == 0)
			literal = acc;
		a = (op_code == 3 || op_code == 7) ? literal : file_rdata;
		case (op_code)
			2: r = {carry_in, a[7:1]};
			3, 4: r = a - acc;
			5: r = {a[3:0], a[7:4]};
			default: r = a ^ acc;
		endcase
		w = dest_bit && op_code inside {2, 4, 5, 6};
		#1 ck("raddr", file_raddr, file_addr);
		@(negedge core_clk);
		if (op_code == 1)
		begin
			ck("pop", {stack_pop, pc_load, flags_we, op_ready}, 4'hc);
			ck("pc", pc_value, stack_top_entry);
			@(negedge core_clk);
			ck("done", {op_done, op_ready}, 2'h3);
		end
		else
		begin
			ck("we", w ? {file_we, file_waddr, file_wdata} : file_we, w ? {1'b1, file_addr, r} : 0);
			if (op_code inside {3, 4})
			begin
				carry_in = a >= acc;
				digit_carry_in = a[3:0] >= acc[3:0];
			end
			if (op_code == 2)
				carry_in = a[0];
			if (!w && op_code != 0)
				acc = r;
			if (op_code > 2 && op_code != 5)
				zero_in = r == 0;
			ck("res", {acc_r, carry_flag, digit_carry_flag, zero_flag, flags_we, op_done},
				{acc, carry_in, digit_carry_in, zero_in, !(op_code inside {0, 5}), op_code != 0});
		end
	end
	end_of_test;
end
endmodule // tb
